/* File: rtl/jlc_pkg.sv */
/*
 * jlc_pkg: shared constants and carrier types for the receiver link and
 * latency control block: register offsets, field widths, reset values,
 * subclass codes and the register-port struct.
 * Assumes: a single 40 MHz clock domain and a byte-wide register port.
 */
package jlc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int LAT_W = 5;
    localparam int EN_W = 2;
    localparam int SUB_W = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] LINK_CTRL_ADDR = 12'h300;
    localparam logic [ADDR_W-1:0] SUBCLASS_ADDR = 12'h301;
    localparam logic [ADDR_W-1:0] MEAS_LAT0_ADDR = 12'h302;
    localparam logic [ADDR_W-1:0] MEAS_LAT1_ADDR = 12'h303;
    localparam logic [ADDR_W-1:0] MF_OFS0_ADDR = 12'h304;
    localparam logic [ADDR_W-1:0] MF_OFS1_ADDR = 12'h305;
    localparam logic [ADDR_W-1:0] BUF_REL0_ADDR = 12'h306;
    localparam logic [ADDR_W-1:0] BUF_REL1_ADDR = 12'h307;

    // reset values and counter constants
    localparam logic [EN_W-1:0] LINK_EN_RST = 2'h0;
    localparam logic [SUB_W-1:0] SUBCLASS_RST = 3'h1;
    localparam logic [LAT_W-1:0] MF_OFS_RST = 5'h00;
    localparam logic [LAT_W-1:0] BUF_REL_RST = 5'h06;
    localparam logic [LAT_W-1:0] LAT_ZERO = 5'h00;
    localparam logic [LAT_W-1:0] LAT_ONE = 5'h01;
    localparam logic [LAT_W-1:0] LAT_MAX = 5'h1f;
    localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

    // subclass codes
    localparam logic [SUB_W-1:0] SUBCLASS_0 = 3'h0;
    localparam logic [SUB_W-1:0] SUBCLASS_1 = 3'h1;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } jlc_req_t;

    // per-link timing inputs, raw pins that jlc_top synchronises to clk_in
    typedef struct packed {
        logic mf_local;
        logic frame_tick;
        logic mf_arrive;
    } jlc_link_in_t;
endpackage

/* File: rtl/jlc_link_timing.sv */
/*
 * jlc_link_timing: one receive link's multiframe delay, arrival latency
 * measure and buffer release strobe.
 * Assumes: inputs synchronised by the parent; one clock, sync reset.
 */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module jlc_link_timing (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic subclass1_in,
    input wire logic [jlc_pkg::LAT_W-1:0] mf_offset_in,
    input wire logic [jlc_pkg::LAT_W-1:0] buf_release_in,
    input wire logic mf_local_in,
    input wire logic frame_tick_in,
    input wire logic mf_arrive_in,
    output logic mf_rx_out,
    output logic release_out,
    output logic aligned_out,
    output logic [jlc_pkg::LAT_W-1:0] latency_out
);
    import jlc_pkg::*;

    typedef enum logic [1:0] {IDLE_S, WAIT_S, RUN_S} jlc_dly_t;
    typedef enum logic [1:0] {OFF_S, WAIT_RX_S, MEAS_S, HELD_S} jlc_meas_t;

    // saturating increment
    function automatic logic [LAT_W-1:0] sat_inc(input logic [LAT_W-1:0] v);
        return (v == LAT_MAX) ? v : LAT_W'(v + LAT_ONE);
    endfunction

    jlc_dly_t dly_r, dly_nxt;
    logic [LAT_W-1:0] dcnt_r, dcnt_nxt;
    logic mf_rx_r, mf_rx_nxt;
    jlc_meas_t meas_r, meas_nxt;
    logic [LAT_W-1:0] mcnt_r, mcnt_nxt;
    logic [LAT_W-1:0] lat_r, lat_nxt;
    logic [LAT_W-1:0] rcnt_r, rcnt_nxt;
    logic rel_pend_r, rel_pend_nxt;
    logic rel_r, rel_nxt;
    logic dly_tick;

    // offset counts frame ticks in subclass 1, clock cycles in subclass 0
    assign dly_tick = subclass1_in ? frame_tick_in : 1'b1;

    // delay local multiframe clock by the programmed offset
    always_comb begin
        dly_nxt = dly_r;
        dcnt_nxt = dcnt_r;
        mf_rx_nxt = 1'b0;
        case (dly_r)
            IDLE_S: begin
                if (enable_in && mf_local_in) begin
                    if (mf_offset_in == LAT_ZERO) begin
                        mf_rx_nxt = 1'b1;
                    end else begin
                        dly_nxt = WAIT_S;
                        dcnt_nxt = LAT_ONE;
                    end
                end
            end
            WAIT_S: begin
                if (dly_tick) begin
                    if (dcnt_r >= mf_offset_in) begin
                        mf_rx_nxt = 1'b1;
                        dly_nxt = IDLE_S;
                    end else begin
                        dcnt_nxt = sat_inc(dcnt_r);
                    end
                end
            end
            default: dly_nxt = IDLE_S;
        endcase
        if (!enable_in) begin
            dly_nxt = IDLE_S;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dly_r <= IDLE_S;
            dcnt_r <= LAT_ZERO;
            mf_rx_r <= 1'b0;
        end else begin
            dly_r <= dly_nxt;
            dcnt_r <= dcnt_nxt;
            mf_rx_r <= mf_rx_nxt;
        end
    end

    // measure from rx multiframe edge to last arriving boundary, then hold
    always_comb begin
        meas_nxt = meas_r;
        mcnt_nxt = mcnt_r;
        lat_nxt = lat_r;
        case (meas_r)
            OFF_S: begin
                if (enable_in) begin
                    meas_nxt = WAIT_RX_S;
                end
            end
            WAIT_RX_S: begin
                if (mf_rx_r) begin
                    meas_nxt = MEAS_S;
                    mcnt_nxt = LAT_ZERO;
                end
            end
            MEAS_S: begin
                if (mf_arrive_in) begin
                    lat_nxt = mcnt_r;
                    meas_nxt = HELD_S;
                end else begin
                    mcnt_nxt = sat_inc(mcnt_r);
                end
            end
            HELD_S: ;
            default: meas_nxt = OFF_S;
        endcase
        if (!enable_in) begin
            meas_nxt = OFF_S;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meas_r <= OFF_S;
            mcnt_r <= LAT_ZERO;
            lat_r <= LAT_ZERO;
        end else begin
            meas_r <= meas_nxt;
            mcnt_r <= mcnt_nxt;
            lat_r <= lat_nxt;
        end
    end

    // release buffered data a set count after each rx multiframe edge
    always_comb begin
        rcnt_nxt = rcnt_r;
        rel_pend_nxt = rel_pend_r;
        rel_nxt = 1'b0;
        if (mf_rx_r) begin
            rel_pend_nxt = 1'b1;
            rcnt_nxt = LAT_ZERO;
        end else if (rel_pend_r) begin
            if (rcnt_r >= buf_release_in) begin
                rel_nxt = 1'b1;
                rel_pend_nxt = 1'b0;
            end else begin
                rcnt_nxt = sat_inc(rcnt_r);
            end
        end
        if (!enable_in) begin
            rel_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rcnt_r <= LAT_ZERO;
            rel_pend_r <= 1'b0;
            rel_r <= 1'b0;
        end else begin
            rcnt_r <= rcnt_nxt;
            rel_pend_r <= rel_pend_nxt;
            rel_r <= rel_nxt;
        end
    end

    assign mf_rx_out = mf_rx_r;
    assign release_out = rel_r;
    assign aligned_out = (meas_r == HELD_S);
    assign latency_out = lat_r;
endmodule

/* File: rtl/jlc_top.sv */
/*
 * jlc_top: control and status registers for two receive links: link
 * enables, subclass, multiframe offsets, buffer release points and
 * measured link latency, with per-link timing logic.
 * Assumes: timing pins come from outside and are synchronised here;
 * register port is same-clock, read data one cycle after the strobe.
 */
// Summary of operation
// - enable field has one bit per link; 01, 10, 11 enable links.
// - enable value 00 keeps both receiver links disabled.
// - subclass 000 or 001; offset counts clock cycles or frame ticks.
// - read-only 5-bit latency from rx multiframe to last boundary.
// - rx multiframe clock delayed from local by programmed 5-bit offset.
// - 5-bit buffer release delay per link, resets to six.
`timescale 1ns/1ps
module jlc_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire jlc_pkg::jlc_req_t req_in,
    output logic [jlc_pkg::DATA_W-1:0] rdata_out,
    input wire logic mf_local_in,
    input wire logic frame_tick_in,
    input wire logic [1:0] mf_arrive_in,
    output logic [1:0] link_en_out,
    output logic [1:0] mf_rx_out,
    output logic [1:0] release_out,
    output logic [1:0] aligned_out
);
    import jlc_pkg::*;

    // zero-extend a 5-bit field into a read byte
    function automatic logic [DATA_W-1:0] ext5(input logic [LAT_W-1:0] v);
        return {{(DATA_W-LAT_W){1'b0}}, v};
    endfunction

    logic [EN_W-1:0] en_r, en_nxt;
    logic [SUB_W-1:0] sub_r, sub_nxt;
    logic [LAT_W-1:0] ofs_r [2];
    logic [LAT_W-1:0] ofs_nxt [2];
    logic [LAT_W-1:0] rel_r [2];
    logic [LAT_W-1:0] rel_nxt [2];
    logic [DATA_W-1:0] rd_r, rd_nxt;
    logic [1:0] sync1_r, sync2_r;
    logic [1:0] arr1_r, arr2_r;
    logic [1:0] mf_rx_r, rel_o_r, al_r;
    logic [1:0] mf_rx_w, rel_w, al_w;
    logic [LAT_W-1:0] lat_w [2];
    logic sub1;

    // subclass 1 selects frame-tick counting of the offset
    assign sub1 = (sub_r == SUBCLASS_1);

    // register writes
    always_comb begin
        en_nxt = en_r;
        sub_nxt = sub_r;
        ofs_nxt = ofs_r;
        rel_nxt = rel_r;
        if (req_in.wr) begin
            case (req_in.addr)
                LINK_CTRL_ADDR: en_nxt = req_in.wdata[EN_W-1:0];
                SUBCLASS_ADDR: sub_nxt = req_in.wdata[SUB_W-1:0];
                MF_OFS0_ADDR: ofs_nxt[0] = req_in.wdata[LAT_W-1:0];
                MF_OFS1_ADDR: ofs_nxt[1] = req_in.wdata[LAT_W-1:0];
                BUF_REL0_ADDR: rel_nxt[0] = req_in.wdata[LAT_W-1:0];
                BUF_REL1_ADDR: rel_nxt[1] = req_in.wdata[LAT_W-1:0];
                default: ;
            endcase
        end
    end

    // register reads, zero for unmapped addresses
    always_comb begin
        rd_nxt = RD_ZERO;
        if (req_in.rd) begin
            case (req_in.addr)
                LINK_CTRL_ADDR: rd_nxt = {{(DATA_W-EN_W){1'b0}}, en_r};
                SUBCLASS_ADDR: rd_nxt = {{(DATA_W-SUB_W){1'b0}}, sub_r};
                MEAS_LAT0_ADDR: rd_nxt = ext5(lat_w[0]);
                MEAS_LAT1_ADDR: rd_nxt = ext5(lat_w[1]);
                MF_OFS0_ADDR: rd_nxt = ext5(ofs_r[0]);
                MF_OFS1_ADDR: rd_nxt = ext5(ofs_r[1]);
                BUF_REL0_ADDR: rd_nxt = ext5(rel_r[0]);
                BUF_REL1_ADDR: rd_nxt = ext5(rel_r[1]);
                default: rd_nxt = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            en_r <= LINK_EN_RST;
            sub_r <= SUBCLASS_RST;
            ofs_r[0] <= MF_OFS_RST;
            ofs_r[1] <= MF_OFS_RST;
            rel_r[0] <= BUF_REL_RST;
            rel_r[1] <= BUF_REL_RST;
            rd_r <= RD_ZERO;
        end else begin
            en_r <= en_nxt;
            sub_r <= sub_nxt;
            ofs_r <= ofs_nxt;
            rel_r <= rel_nxt;
            rd_r <= rd_nxt;
        end
    end

    // two-flop synchronisers for the timing pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            arr1_r <= 2'h0;
            arr2_r <= 2'h0;
        end else begin
            sync1_r <= {frame_tick_in, mf_local_in};
            sync2_r <= sync1_r;
            arr1_r <= mf_arrive_in;
            arr2_r <= arr1_r;
        end
    end

    // one timing unit per link, each gated by its enable bit
    for (genvar i = 0; i < 2; i++) begin : g_link
        jlc_link_timing u_link (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .enable_in(en_r[i]),
            .subclass1_in(sub1),
            .mf_offset_in(ofs_r[i]),
            .buf_release_in(rel_r[i]), // software keeps it at ten or below
            .mf_local_in(sync2_r[0]),
            .frame_tick_in(sync2_r[1]),
            .mf_arrive_in(arr2_r[i]),
            .mf_rx_out(mf_rx_w[i]),
            .release_out(rel_w[i]),
            .aligned_out(al_w[i]),
            .latency_out(lat_w[i])
        );
    end

    // register the outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mf_rx_r <= 2'h0;
            rel_o_r <= 2'h0;
            al_r <= 2'h0;
        end else begin
            mf_rx_r <= mf_rx_w;
            rel_o_r <= rel_w;
            al_r <= al_w;
        end
    end

    assign rdata_out = rd_r;
    assign link_en_out = en_r;
    assign mf_rx_out = mf_rx_r;
    assign release_out = rel_o_r;
    assign aligned_out = al_r;
endmodule

/* File: tb/jlc_monitor.sv */
/* jlc_monitor: port-level checks on the link control block.
   Assumes one clock, sync active-high reset; bound to jlc_top. */
`timescale 1ns/1ps
module jlc_monitor import jlc_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire jlc_req_t req_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic mf_local_in,
    input wire logic frame_tick_in,
    input wire logic [1:0] mf_arrive_in,
    input wire logic [1:0] link_en_out,
    input wire logic [1:0] mf_rx_out,
    input wire logic [1:0] release_out,
    input wire logic [1:0] aligned_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic en_wr;
    logic [4:0] rel_r, rel_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    assign en_wr = req_in.wr && req_in.addr == LINK_CTRL_ADDR;
    // shadow of link zero release point and its countdown
    always_comb begin
        rel_nxt = rel_r;
        if (req_in.wr && req_in.addr == BUF_REL0_ADDR)
            rel_nxt = req_in.wdata[4:0];
        cnt_nxt = (cnt_r != 6'h00) ? cnt_r - 6'h01 : cnt_r;
        if (mf_rx_out[0])
            cnt_nxt = {1'b0, rel_r} + 6'h02;
        if (!link_en_out[0])
            cnt_nxt = 6'h00;
    end
    always_ff @(posedge clk_in) begin
        rel_r <= rst_in ? BUF_REL_RST : rel_nxt;
        cnt_r <= rst_in ? 6'h00 : cnt_nxt;
    end
    sequence s_held;
        aligned_out[1] && link_en_out[1] ##1 link_en_out[1];
    endsequence
    sequence s_sub_rd;
        req_in.rd && req_in.addr == SUBCLASS_ADDR;
    endsequence
    a_enable_write: assert property (en_wr |=> link_en_out == $past(req_in.wdata[1:0]))
        else $error("link enable differs from written value");
    a_enable_hold: assert property (!en_wr |=> $stable(link_en_out))
        else $error("link enable moved without a write");
    a_off_quiet: assert property ((link_en_out == 2'h0) [*3] |-> aligned_out == 2'h0)
        else $error("aligned while both links disabled");
    a_release_time: assert property (cnt_r == 6'h01 && link_en_out[0] |-> release_out[0])
        else $error("buffer release missing at programmed point");
    a_rx_pulse: assert property (mf_rx_out[0] |=> !mf_rx_out[0])
        else $error("rx multiframe pulse longer than one cycle");
    a_aligned_hold: assert property (s_held |-> aligned_out[1])
        else $error("aligned dropped while link enabled");
    a_read_resv: assert property ($past(req_in.rd) |-> rdata_out[7:5] == 3'h0)
        else $error("reserved read bits not zero");
    a_read_idle: assert property (!$past(req_in.rd) |-> rdata_out == RD_ZERO)
        else $error("read data outside read cycle");
    a_sub_resv: assert property (s_sub_rd |=> rdata_out[7:3] == 5'h00)
        else $error("subclass register high bits not zero");
endmodule
bind jlc_top jlc_monitor jlc_monitor_inst (.clk_in(clk_in), .rst_in(rst_in),
    .req_in(req_in), .rdata_out(rdata_out), .mf_local_in(mf_local_in),
    .frame_tick_in(frame_tick_in), .mf_arrive_in(mf_arrive_in),
    .link_en_out(link_en_out), .mf_rx_out(mf_rx_out),
    .release_out(release_out), .aligned_out(aligned_out));

/* File: tb/jlc_tx_model.sv */
/* jlc_tx_model: far-side timing source: local multiframe, frame ticks and
   per-link boundary arrival a set gap after each rx multiframe pulse. */
`timescale 1ns/1ps
module jlc_tx_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] mf_rx_in,
    input wire logic [4:0] gap_in,
    output logic mf_local_out = 1'b0,
    output logic frame_tick_out = 1'b0,
    output logic [1:0] mf_arrive_out = 2'h0
);
    logic [5:0] ph_r, ph_nxt;
    logic [5:0] cnt_r [2];
    logic [5:0] cnt_nxt [2];
    // multiframe every 40 cycles, frame tick every second cycle
    always_comb begin
        ph_nxt = (ph_r == 6'h27) ? 6'h00 : ph_r + 6'h01;
        for (int i = 0; i < 2; i++) begin
            cnt_nxt[i] = (cnt_r[i] != 6'h00) ? cnt_r[i] - 6'h01 : 6'h00;
            if (mf_rx_in[i])
                cnt_nxt[i] = {1'b0, gap_in} + 6'h01;
        end
    end
    always @(posedge clk_in) begin
        ph_r <= rst_in ? 6'h00 : ph_nxt;
        for (int i = 0; i < 2; i++)
            cnt_r[i] <= rst_in ? 6'h00 : cnt_nxt[i];
        mf_local_out <= !rst_in && ph_r == 6'h00;
        frame_tick_out <= !rst_in && ph_r[0];
        mf_arrive_out <= rst_in ? 2'h0 : {cnt_r[1] == 6'h01, cnt_r[0] == 6'h01};
    end
endmodule

/* File: tb/jlc_top_tb.sv */
/* jlc_top_tb: register, delay, release and latency tests of jlc_top.
   Assumes the tx model drives the timing pins. */
`timescale 1ns/1ps
module jlc_top_tb;
    import jlc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    jlc_req_t req_in = '0;
    logic [7:0] rdata_out;
    logic mf_local_in, frame_tick_in;
    logic [1:0] mf_arrive_in, link_en_out, mf_rx_out, release_out, aligned_out;
    logic [4:0] gap_r = 5'h02;
    logic [7:0] rst_tab [9] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h06, 8'h06, 8'h00};
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 clk_in = ~clk_in;
    jlc_top jlc_top_inst (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
        .rdata_out(rdata_out), .mf_local_in(mf_local_in),
        .frame_tick_in(frame_tick_in), .mf_arrive_in(mf_arrive_in),
        .link_en_out(link_en_out), .mf_rx_out(mf_rx_out),
        .release_out(release_out), .aligned_out(aligned_out));
    jlc_tx_model jlc_tx_model_inst (.clk_in(clk_in), .rst_in(rst_in),
        .mf_rx_in(mf_rx_out), .gap_in(gap_r), .mf_local_out(mf_local_in),
        .frame_tick_out(frame_tick_in), .mf_arrive_out(mf_arrive_in));
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            summarize;
        end
    end
    task automatic chk(input string nm, input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_in.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_in);
        req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_in.rd <= 1'b0;
        #1 d = rdata_out;
    endtask
    // writable bits of each offset from 0x300
    function automatic logic [7:0] mask_of(input int a);
        return a == 0 ? 8'h03 : a == 1 ? 8'h07 : (a == 2 || a == 3) ? 8'h00 :
            a < 8 ? 8'h1f : 8'h00;
    endfunction
    // local pulse to rx pulse, rx pulse to release, in cycles
    task automatic meas(input int l, output int dm, output int dr);
        int n;
        n = 0;
        do begin tick; n++; end while (!mf_local_in && n < 100);
        dm = 0;
        do begin tick; dm++; end while (!mf_rx_out[l] && dm < 100);
        dr = 0;
        while (!release_out[l] && dr < 100) begin tick; dr++; end
    endtask
    initial begin
        logic [7:0] d, v, l0;
        int a, b, k, r, dm0, dm1, dr;
        void'($urandom(32'h7282));
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        for (a = 0; a < 9; a++) begin
            rd(LINK_CTRL_ADDR + 12'(a), d);
            chk("reset value", d, rst_tab[a]);
        end
        repeat (24) begin
            a = $urandom_range(8);
            v = 8'($urandom);
            if (a >= 6 && a < 8)
                v = 8'($urandom_range(10));
            // links stay off here so the latency fields read zero
            if (a == 0)
                v[1:0] = 2'h0;
            wr(LINK_CTRL_ADDR + 12'(a), v);
            rd(LINK_CTRL_ADDR + 12'(a), d);
            chk("readback", d, v & mask_of(a));
        end
        $display("register test done");
        for (a = 3; a >= 0; a--) begin
            wr(LINK_CTRL_ADDR, 8'(a));
            rd(LINK_CTRL_ADDR, d);
            chk("enable readback", d, 8'(a));
            tick;
            chk("link enable", {6'h00, link_en_out}, 8'(a));
        end
        repeat (60) tick;
        chk("idle aligned", {6'h00, aligned_out}, 8'h00);
        $display("enable test done");
        for (b = 0; b < 2; b++) begin
            wr(SUBCLASS_ADDR, 8'(b));
            r = $urandom_range(10);
            wr(BUF_REL0_ADDR + 12'(b), 8'(r));
            wr(LINK_CTRL_ADDR, 8'h03);
            wr(MF_OFS0_ADDR + 12'(b), 8'h01);
            meas(b, dm0, dr);
            chk("release", 8'(dr), 8'(r + 2));
            wr(MF_OFS0_ADDR + 12'(b), 8'h03);
            meas(b, dm1, dr);
            chk("offset step", 8'(dm1 - dm0), b ? 8'h04 : 8'h02);
        end
        $display("delay test done");
        for (b = 0; b < 2; b++) begin
            for (k = 0; k < 2; k++) begin
                gap_r <= 5'(2 + 5 * k);
                wr(LINK_CTRL_ADDR, 8'h00);
                repeat (50) tick;
                wr(LINK_CTRL_ADDR, 8'h03);
                r = 0;
                while (!aligned_out[b] && r < 200) begin tick; r++; end
                l0 = d;
                rd(MEAS_LAT0_ADDR + 12'(b), d);
            end
            chk("latency step", d - l0, 8'h05);
            gap_r <= 5'h0c;
            repeat (90) tick;
            rd(MEAS_LAT0_ADDR + 12'(b), v);
            chk("latency held", v, d);
        end
        $display("latency test done");
        summarize;
    end
endmodule
